// ===== logic/sic_pkg.sv
/*
 * Shared constants of the system integrity control and status block:
 * register offsets, field positions, reset values, bus responses and
 * the power-up delay counts.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package sic_pkg;

    // ******************************************************
    // Bus widths and register offsets
    // ******************************************************
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [AW-1:0] OFS_ICSR = 8'h00;
    localparam logic [AW-1:0] OFS_ISTS = 8'h04;
    localparam logic [AW-1:0] OFS_IMSK = 8'h08;

    // ******************************************************
    // Control/status field positions and reset value
    // ******************************************************
    localparam int POS_SRC = 7;
    localparam int POS_IE = 6;
    localparam int POS_FLAG = 5;
    localparam int POS_LVRF = 4;
    localparam int POS_WDRF = 0;
    localparam logic [7:0] ICSR_RST = 8'h00;

    // ******************************************************
    // Interrupt status layout and reset values
    // ******************************************************
    localparam int ST_TOGGLE = 0;
    localparam int ST_LVRST = 1;
    localparam int ST_W = 2;
    localparam logic [ST_W-1:0] ISTS_RST = 2'h0;
    localparam logic [ST_W-1:0] IMSK_RST = 2'h0;

    // ******************************************************
    // Bus responses
    // ******************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ******************************************************
    // Start-up delay in CPU cycles
    // ******************************************************
    localparam int DLY_W = 13;
    localparam logic [DLY_W-1:0] DLY_SHORT = 13'h0100;
    localparam logic [DLY_W-1:0] DLY_LONG = 13'h1000;

endpackage

// ===== logic/sic_det_if.sv
/*
 * Link between the register core and the detector front end.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface sic_det_if;
    logic sel;
    logic run;
    logic lvd_on;
    logic flag;
    logic tog_up;
    logic tog_down;
    modport core (output sel, output run, output lvd_on,
                  input flag, input tog_up, input tog_down);
    modport det (input sel, input run, input lvd_on,
                 output flag, output tog_up, output tog_down);
endinterface

// ===== logic/sic_detector.sv
/*
 * Detector front end: synchronises both comparator outputs, picks the
 * watched source, holds the detector flag and pulses on each toggle.
 * Assumes comparator outputs are asynchronous levels from analog cells.
 */
`timescale 1ns/100ps
module sic_detector (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Analog comparator outputs, high while below the lower threshold
    input wire logic cmp_supply,
    input wire logic cmp_pin,
    // Core side
    sic_det_if.det det
);
    import sic_pkg::*;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic flag;
        logic up;
        logic down;
    } sic_det_s;

    sic_det_s st_r;
    sic_det_s st_nxt;
    logic picked;

    always_comb begin
        st_nxt = st_r;
        picked = det.sel ? st_r.sync2[1] : st_r.sync2[0];
        st_nxt.sync1 = {cmp_pin, cmp_supply};
        st_nxt.sync2 = st_r.sync1;
        st_nxt.up = 1'b0;
        st_nxt.down = 1'b0;
        if (!aresetn) begin
            st_nxt = '0;
        end else if (!det.lvd_on) begin
            // Detection is dead without the low-voltage detector
            st_nxt.flag = 1'b0;
        end else if (det.run && picked != st_r.flag) begin
            st_nxt.flag = picked;
            st_nxt.up = !picked;
            st_nxt.down = picked;
        end
    end

    always_ff @(posedge aclk) begin
        st_r <= st_nxt;
    end

    assign det.flag = st_r.flag;
    assign det.tog_up = st_r.up;
    assign det.tog_down = st_r.down;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    flag_gate_a: assert property (!det.lvd_on |=> !det.flag)
        else $error("detector flag set while detection disabled");
    // Compare with the pick of the previous edge; the synchroniser may move on the checked edge
    flag_follow_a: assert property ((det.run && det.lvd_on && $stable(det.sel)
        && $stable(st_r.sync2)) [*3] |=> det.flag == $past(picked))
        else $error("detector flag does not follow comparator");

endmodule

// ===== logic/sic_top.sv
/*
 * System integrity control and status block: detector source select,
 * detector interrupt, reset cause flags, AXI4-Lite register slave.
 * Assumes the reset manager holds its cause inputs during aresetn low
 * and the CPU pulses irq_ack on entry to the detector service routine.
 */
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps

module sic_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [sic_pkg::AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [sic_pkg::DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [sic_pkg::AW-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [sic_pkg::DW-1:0] rdata,
    output logic [1:0] rresp,
    // Comparator outputs, asynchronous
    input wire logic cmp_supply,
    input wire logic cmp_pin,
    // Option settings, static
    input wire logic lvd_enable,
    input wire logic delay_long,
    // Reset causes, valid while aresetn is low
    input wire logic rst_src_por,
    input wire logic rst_src_lvd,
    input wire logic rst_src_wdg,
    // CPU and interrupt controller
    input wire logic halt_mode,
    input wire logic cc_imask,
    input wire logic irq_ack,
    output logic cpu_irq,
    output logic wait_wake,
    // Summary interrupt
    output logic irq
);
    import sic_pkg::*;

    typedef struct packed {
        logic src_sel;
        logic irq_en;
        logic lv_rf;
        logic wd_rf;
        logic pend;
        logic [ST_W-1:0] ists;
        logic [ST_W-1:0] imask;
        logic long_dly;
        logic [DLY_W-1:0] dly_cnt;
        logic aw_held;
        logic [AW-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_be;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [DW-1:0] rdata;
        logic irq;
        logic cpu_irq;
        logic wake;
    } sic_state_s;

    sic_state_s st_r;
    sic_state_s st_nxt;
    sic_det_if det_link ();
    logic [7:0] icsr_view;
    logic dly_act;
    logic req_set;

    // ******************************************************
    // Detector front end
    // ******************************************************
    assign det_link.sel = st_r.src_sel;
    assign det_link.lvd_on = lvd_enable;
    assign det_link.run = !halt_mode;

    sic_detector u_det (
        .aclk(aclk),
        .aresetn(aresetn),
        .cmp_supply(cmp_supply),
        .cmp_pin(cmp_pin),
        .det(det_link.det)
    );

    // ******************************************************
    // Register view and request source
    // ******************************************************
    always_comb begin
        icsr_view = ICSR_RST;
        icsr_view[POS_SRC] = st_r.src_sel;
        icsr_view[POS_IE] = st_r.irq_en;
        icsr_view[POS_FLAG] = det_link.flag;
        icsr_view[POS_LVRF] = st_r.lv_rf;
        icsr_view[POS_WDRF] = st_r.wd_rf;
    end

    // A fast supply rise is hidden inside the reset delay
    assign dly_act = st_r.dly_cnt < (st_r.long_dly ? DLY_LONG : DLY_SHORT);
    assign req_set = st_r.irq_en && lvd_enable
        && (det_link.tog_down || (det_link.tog_up && !dly_act));

    // ******************************************************
    // Next state
    // ******************************************************
    always_comb begin
        st_nxt = st_r;
        if (!aresetn) begin
            st_nxt = '0;
            st_nxt.src_sel = ICSR_RST[POS_SRC];
            st_nxt.irq_en = ICSR_RST[POS_IE];
            st_nxt.ists = ISTS_RST;
            st_nxt.imask = IMSK_RST;
            st_nxt.long_dly = delay_long;
            st_nxt.lv_rf = st_r.lv_rf;
            st_nxt.wd_rf = st_r.wd_rf;
            if (rst_src_lvd) begin
                st_nxt.lv_rf = 1'b1;
                st_nxt.wd_rf = 1'b0;
                st_nxt.ists[ST_LVRST] = 1'b1;
            end else if (rst_src_wdg) begin
                st_nxt.wd_rf = 1'b1;
            end else if (rst_src_por) begin
                st_nxt.lv_rf = 1'b0;
                st_nxt.wd_rf = 1'b0;
            end
        end else begin
            st_nxt.awready = 1'b0;
            st_nxt.wready = 1'b0;
            st_nxt.arready = 1'b0;
            if (dly_act) begin
                st_nxt.dly_cnt = st_r.dly_cnt + 13'h0001;
            end

            // Write address and data, either order
            if (awvalid && st_r.awready) begin
                st_nxt.aw_held = 1'b1;
                st_nxt.aw_addr = awaddr;
            end
            if (wvalid && st_r.wready) begin
                st_nxt.w_held = 1'b1;
                st_nxt.w_data = wdata[7:0];
                st_nxt.w_be = wstrb[0];
            end
            if (st_r.bvalid && bready) begin
                st_nxt.bvalid = 1'b0;
            end

            // Request latch, service entry clears, set wins
            if (irq_ack) begin
                st_nxt.pend = 1'b0;
            end
            if (det_link.tog_up || det_link.tog_down) begin
                st_nxt.ists[ST_TOGGLE] = 1'b1;
            end

            if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
                st_nxt.aw_held = 1'b0;
                st_nxt.w_held = 1'b0;
                st_nxt.bvalid = 1'b1;
                st_nxt.bresp = RESP_OKAY;
                if (st_r.aw_addr == OFS_ICSR) begin
                    // Frozen in halt; reserved bits are dropped
                    if (st_r.w_be && !halt_mode) begin
                        st_nxt.src_sel = st_r.w_data[POS_SRC];
                        st_nxt.irq_en = st_r.w_data[POS_IE];
                        if (!st_r.w_data[POS_LVRF]) begin
                            st_nxt.lv_rf = 1'b0;
                        end
                        if (!st_r.w_data[POS_WDRF]) begin
                            st_nxt.wd_rf = 1'b0;
                        end
                    end
                end else if (st_r.aw_addr == OFS_ISTS) begin
                    if (st_r.w_be) begin
                        st_nxt.ists = st_nxt.ists & ~st_r.w_data[ST_W-1:0];
                        if (det_link.tog_up || det_link.tog_down) begin
                            st_nxt.ists[ST_TOGGLE] = 1'b1;
                        end
                    end
                end else if (st_r.aw_addr == OFS_IMSK) begin
                    if (st_r.w_be) begin
                        st_nxt.imask = st_r.w_data[ST_W-1:0];
                    end
                end else begin
                    st_nxt.bresp = RESP_DECERR;
                end
            end
            if (req_set) begin
                st_nxt.pend = 1'b1;
            end
            if (halt_mode) begin
                st_nxt.pend = st_r.pend;
            end

            // Read channel
            if (st_r.rvalid && rready) begin
                st_nxt.rvalid = 1'b0;
            end
            if (arvalid && st_r.arready) begin
                st_nxt.rvalid = 1'b1;
                st_nxt.rresp = RESP_OKAY;
                st_nxt.rdata = '0;
                if (araddr == OFS_ICSR) begin
                    st_nxt.rdata[7:0] = icsr_view;
                end else if (araddr == OFS_ISTS) begin
                    st_nxt.rdata[ST_W-1:0] = st_r.ists;
                end else if (araddr == OFS_IMSK) begin
                    st_nxt.rdata[ST_W-1:0] = st_r.imask;
                end else begin
                    st_nxt.rresp = RESP_DECERR;
                end
            end

            // Ready only while the slot is free for the next edge
            st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
            st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;
            st_nxt.arready = !st_nxt.rvalid;

            st_nxt.irq = |(st_nxt.ists & st_nxt.imask);
            st_nxt.cpu_irq = st_nxt.pend && !cc_imask;
            st_nxt.wake = st_nxt.pend && !halt_mode;
        end
    end

    always_ff @(posedge aclk) begin
        st_r <= st_nxt;
    end

    // ******************************************************
    // Outputs
    // ******************************************************
    assign awready = st_r.awready;
    assign wready = st_r.wready;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = st_r.arready;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign cpu_irq = st_r.cpu_irq;
    assign wait_wake = st_r.wake;
    assign irq = st_r.irq;

    // ******************************************************
    // Checks
    // ******************************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ctrl_reset_a: assert property ($rose(aresetn) |-> !st_r.src_sel && !st_r.irq_en)
        else $error("control bits not clear after reset");
    pend_set_a: assert property (req_set && !halt_mode |=> st_r.pend)
        else $error("enabled toggle did not latch request");
    pend_ack_a: assert property (irq_ack && !req_set && !halt_mode |=> !st_r.pend)
        else $error("service entry did not clear request");
    rise_quiet_a: assert property (dly_act && det_link.tog_up && !det_link.tog_down
        && !st_r.pend |=> !st_r.pend)
        else $error("rising-edge request inside reset delay");
    halt_freeze_a: assert property (halt_mode |=> $stable({st_r.src_sel, st_r.irq_en,
        st_r.lv_rf, st_r.wd_rf, st_r.pend}))
        else $error("register changed during halt");
    // Request and mask are registered together, so the pending bit is seen on the same edge
    cpu_mask_a: assert property (st_r.cpu_irq |-> st_r.pend && !$past(cc_imask))
        else $error("cpu request without pending or with mask set");
    wake_path_a: assert property (st_r.pend && !halt_mode && !irq_ack |=> st_r.wake)
        else $error("pending request did not wake from wait");

    // Cause flags are written while aresetn is low, so the default disable is lifted
    lv_cause_a: assert property (disable iff (1'b0) !aresetn && rst_src_lvd
        |=> st_r.lv_rf && !st_r.wd_rf)
        else $error("low-voltage reset flags wrong");

    lv_keep_a: assert property (disable iff (1'b0) !aresetn && !rst_src_lvd
        && !rst_src_por |=> $stable(st_r.lv_rf))
        else $error("pin or watchdog reset changed low-voltage flag");

    wr_resp_a: assert property (st_r.aw_held && st_r.w_held && !st_r.bvalid
        |=> st_r.bvalid)
        else $error("write response missing");

endmodule

// ===== tb/sic_cpu_model.sv
/*
 * CPU core and interrupt controller model: takes the detector request
 * and enters its service routine after a short latency.
 * Assumes the block's clock and synchronous active-low reset.
 */
`timescale 1ns/100ps
module sic_cpu_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request and service control
    input wire logic cpu_irq,
    input wire logic svc_en,
    // Service entry
    output logic irq_ack,
    output logic [7:0] svc_count
);
    logic [1:0] lat_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_r <= 2'h0;
            irq_ack <= 1'h0;
            svc_count <= 8'h00;
        end else if (irq_ack) begin
            irq_ack <= 1'h0;
            lat_r <= 2'h0;
        end else if (svc_en && cpu_irq) begin
            // Stacking delay, so the request must stand a few cycles
            lat_r <= lat_r + 2'h1;
            if (lat_r == 2'h1) begin
                irq_ack <= 1'h1;
                svc_count <= svc_count + 8'h01;
            end
        end else begin
            lat_r <= 2'h0;
        end
    end
endmodule

// ===== tb/test_system_integrity_status_control.sv
/*
 * Self-checking bench of the integrity block: AXI4-Lite tasks, reset
 * causes, detector requests, low-power modes and the summary interrupt.
 * Assumes the CPU model services requests while svc_en is high.
 */
`timescale 1ns/100ps
module test_system_integrity_status_control;
    import sic_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [AW-1:0] awaddr = 8'h00, araddr = 8'h00;
    logic [DW-1:0] wdata = 32'h0, rdata, rd_v;
    logic [3:0] wstrb = 4'h0;
    logic cmp_supply = 1'h0, cmp_pin = 1'h0, lvd_enable = 1'h1, delay_long = 1'h0;
    logic rst_src_por = 1'h1, rst_src_lvd = 1'h0, rst_src_wdg = 1'h0;
    logic halt_mode = 1'h0, cc_imask = 1'h0, svc_en = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, cpu_irq, wait_wake, irq, irq_ack;
    logic [1:0] bresp, rresp;
    logic [7:0] svc_count;
    logic [2:0] cause_t [6] = '{3'h2, 3'h0, 3'h1, 3'h2, 3'h4, 3'h1};
    logic [7:0] flag_t [6] = '{8'h10, 8'h10, 8'h11, 8'h10, 8'h00, 8'h01};
    int bad_count = 0;
    int checks = 0;

    always #25 aclk = ~aclk;

    sic_top u_sic_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .cmp_supply(cmp_supply), .cmp_pin(cmp_pin),
        .lvd_enable(lvd_enable), .delay_long(delay_long), .rst_src_por(rst_src_por),
        .rst_src_lvd(rst_src_lvd), .rst_src_wdg(rst_src_wdg), .halt_mode(halt_mode),
        .cc_imask(cc_imask), .irq_ack(irq_ack), .cpu_irq(cpu_irq), .wait_wake(wait_wake),
        .irq(irq));

    sic_cpu_model u_sic_cpu_model (.aclk(aclk), .aresetn(aresetn), .cpu_irq(cpu_irq),
        .svc_en(svc_en), .irq_ack(irq_ack), .svc_count(svc_count));

    // ******************************************************
    // Bus and check tasks
    // ******************************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 300) begin
            check("bus_wait", 32'h0, 32'h1);
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic aw_ok;
        logic w_ok;
        n = 0;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            tick(n);
            if (!aw_ok && awready) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        bready <= 1'h1;
        tick(n);
        while (!bvalid) tick(n);
        bready <= 1'h0;
        check("bresp", 32'(bresp), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        tick(n);
        while (!arready) tick(n);
        arvalid <= 1'h0;
        while (!rvalid) tick(n);
        rd_v = rdata;
        rready <= 1'h0;
        check("rresp", 32'(rresp), 32'(er));
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] e);
        rd(a, RESP_OKAY);
        check(nm, rd_v & {24'h0, m}, {24'h0, e});
    endtask

    // Sel picks from {irq, wait_wake, cpu_irq}; any high cycle counts
    task automatic watch(input logic [2:0] sel, input logic e, input int cyc);
        logic seen;
        seen = 1'h0;
        repeat (cyc) begin
            @(posedge aclk);
            seen = seen | (|({irq, wait_wake, cpu_irq} & sel));
        end
        check("irq_lines", 32'(seen), 32'(e));
    endtask

    task automatic do_reset(input logic [2:0] cause);
        @(posedge aclk);
        aresetn <= 1'h0;
        {rst_src_por, rst_src_lvd, rst_src_wdg} <= cause;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        {rst_src_por, rst_src_lvd, rst_src_wdg} <= 3'h0;
        repeat (2) @(posedge aclk);
    endtask

    // ******************************************************
    // Test sequence
    // ******************************************************
    initial begin
        do_reset(3'h4);
        rdc("icsr_rst", OFS_ICSR, 8'hFF, ICSR_RST);
        rdc("ists_rst", OFS_ISTS, 8'hFF, {6'h0, ISTS_RST});
        rdc("imsk_rst", OFS_IMSK, 8'hFF, {6'h0, IMSK_RST});
        rd(8'h0C, RESP_DECERR);
        wr(8'h0C, 8'h00, RESP_DECERR);
        for (int i = 0; i < 6; i++) begin
            do_reset(cause_t[i]);
            rdc("reset_flags", OFS_ICSR, 8'hFF, flag_t[i]);
        end
        // Reserved bits always written as zero
        wr(OFS_ICSR, 8'h11, RESP_OKAY);
        rdc("flags_no_set", OFS_ICSR, 8'hFF, 8'h01);
        wr(OFS_ICSR, 8'h00, RESP_OKAY);
        rdc("wdg_sw_clr", OFS_ICSR, 8'hFF, 8'h00);
        do_reset(3'h2);
        wr(OFS_ICSR, 8'h00, RESP_OKAY);
        rdc("lvd_sw_clr", OFS_ICSR, 8'hFF, 8'h00);
        // Fresh reset so the rise suppression window is open
        do_reset(3'h4);
        wr(OFS_ICSR, 8'h40, RESP_OKAY);
        svc_en <= 1'h1;
        cmp_supply <= 1'h1;
        watch(3'h1, 1'h1, 12);
        check("svc_count", 32'(svc_count), 32'h1);
        check("cpu_irq_clr", 32'(cpu_irq), 32'h0);
        rdc("flag_low", OFS_ICSR, 8'hFF, 8'h60);
        cmp_supply <= 1'h0;
        watch(3'h1, 1'h0, 12);
        rdc("flag_high", OFS_ICSR, 8'hFF, 8'h40);
        repeat (256) @(posedge aclk);
        cmp_supply <= 1'h1;
        watch(3'h1, 1'h1, 12);
        cmp_supply <= 1'h0;
        watch(3'h1, 1'h1, 12);
        check("svc_count", 32'(svc_count), 32'h3);
        cc_imask <= 1'h1;
        cmp_supply <= 1'h1;
        watch(3'h1, 1'h0, 12);
        check("wait_wake", 32'(wait_wake), 32'h1);
        cc_imask <= 1'h0;
        watch(3'h1, 1'h1, 12);
        wr(OFS_ICSR, 8'h00, RESP_OKAY);
        cmp_supply <= 1'h0;
        watch(3'h3, 1'h0, 12);
        wr(OFS_ICSR, 8'h40, RESP_OKAY);
        halt_mode <= 1'h1;
        wr(OFS_ICSR, 8'hC0, RESP_OKAY);
        cmp_supply <= 1'h1;
        watch(3'h3, 1'h0, 12);
        rdc("halt_frozen", OFS_ICSR, 8'hFF, 8'h40);
        halt_mode <= 1'h0;
        watch(3'h1, 1'h1, 12);
        rdc("after_halt", OFS_ICSR, 8'hFF, 8'h60);
        wr(OFS_ICSR, 8'hC0, RESP_OKAY);
        watch(3'h1, 1'h1, 12);
        rdc("src_pin", OFS_ICSR, 8'hFF, 8'hC0);
        cmp_pin <= 1'h1;
        watch(3'h1, 1'h1, 12);
        cmp_supply <= 1'h0;
        watch(3'h1, 1'h0, 8);
        rdc("src_pin_hi", OFS_ICSR, 8'hFF, 8'hE0);
        wr(OFS_ICSR, 8'h40, RESP_OKAY);
        watch(3'h1, 1'h1, 12);
        rdc("src_supply", OFS_ICSR, 8'hFF, 8'h40);
        // Summary interrupt: raise, mask, unmask, clear
        wr(OFS_ISTS, 8'h03, RESP_OKAY);
        wr(OFS_IMSK, 8'h01, RESP_OKAY);
        cmp_supply <= 1'h1;
        watch(3'h4, 1'h1, 12);
        rdc("ists_toggle", OFS_ISTS, 8'h01, 8'h01);
        wr(OFS_IMSK, 8'h00, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("irq_masked", 32'(irq), 32'h0);
        wr(OFS_IMSK, 8'h01, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("irq_unmasked", 32'(irq), 32'h1);
        wr(OFS_ISTS, 8'h01, RESP_OKAY);
        repeat (2) @(posedge aclk);
        check("irq_cleared", 32'(irq), 32'h0);
        cmp_supply <= 1'h0;
        watch(3'h1, 1'h1, 12);
        lvd_enable <= 1'h0;
        repeat (4) @(posedge aclk);
        cmp_supply <= 1'h1;
        watch(3'h3, 1'h0, 12);
        // Undefined flags are not trusted with the detector off
        rdc("lvd_off", OFS_ICSR, 8'hEE, 8'h40);
        // Long start-up delay: a rise stays quiet well past the short count
        delay_long <= 1'h1;
        lvd_enable <= 1'h1;
        cmp_supply <= 1'h0;
        do_reset(3'h4);
        wr(OFS_ICSR, 8'h40, RESP_OKAY);
        cmp_supply <= 1'h1;
        watch(3'h1, 1'h1, 12);
        repeat (400) @(posedge aclk);
        cmp_supply <= 1'h0;
        watch(3'h1, 1'h0, 12);
        repeat (4096) @(posedge aclk);
        cmp_supply <= 1'h1;
        watch(3'h1, 1'h1, 12);
        cmp_supply <= 1'h0;
        watch(3'h1, 1'h1, 12);
        print_verdict();
    end
endmodule
